// ===== core/lrpc_consts.svh
// register indices, field positions, codes and limits of the lane checker
// assumes the includer places registers one per aligned 32-bit word
`ifndef LRPC_CONSTS_SVH
`define LRPC_CONSTS_SVH
// register indices (byte address is four times the index)
`define LRPC_IDX_LOOPBACK 12'h941
`define LRPC_IDX_CTRL 12'h950
`define LRPC_IDX_MODE 12'h952
`define LRPC_IDX_STATUS 12'h953
`define LRPC_IDX_CNT_LO 12'h95b
`define LRPC_IDX_CNT_MID 12'h963
`define LRPC_IDX_CNT_HI 12'h96b
`define LRPC_IDX_USER0 12'h973
`define LRPC_IDX_USER1 12'h974
`define LRPC_IDX_USER2 12'h975
`define LRPC_IDX_USER3 12'h976
`define LRPC_IDX_IRQ_STAT 12'h980
`define LRPC_IDX_IRQ_MASK 12'h981
// address slice holding the index
`define LRPC_IDX_MSB 13
`define LRPC_IDX_LSB 2
// field positions
`define LRPC_BIT_LOOPBACK 0
`define LRPC_BIT_CLEAR 0
`define LRPC_BIT_UPDATE 1
// checker mode codes
`define LRPC_MODE_OFF 3'h0
`define LRPC_MODE_P7 3'h1
`define LRPC_MODE_P9 3'h2
`define LRPC_MODE_P15 3'h3
`define LRPC_MODE_P31 3'h4
`define LRPC_MODE_USER 3'h5
// feedback taps per polynomial
`define LRPC_P7_TA 6
`define LRPC_P7_TB 5
`define LRPC_P9_TA 8
`define LRPC_P9_TB 4
`define LRPC_P15_TA 14
`define LRPC_P15_TB 13
`define LRPC_P31_TA 30
`define LRPC_P31_TB 27
// counter width and full scale
`define LRPC_CNT_W 24
`define LRPC_CNT_MAX 24'hffffff
`define LRPC_RESET_BYTE 8'h00
`endif

// ===== core/lrpc_pkg.sv
// shared types of the lane pattern checker
// assumes lrpc_consts.svh is on the include path
`include "lrpc_consts.svh"
package lrpc_pkg;
  typedef logic [11:0] lrpc_idx_t;
  typedef logic [7:0] lrpc_byte_t;
  typedef logic [`LRPC_CNT_W-1:0] lrpc_cnt_t;
  typedef logic [30:0] lrpc_shreg_t;
  typedef logic [2:0] lrpc_mode_t;
endpackage

// ===== core/lrpc_checker.sv
// per-lane receive pattern checker with apb byte registers
// assumes lane words arrive on i_sys_clk from the receive link, ahead of the receive link fifo
// Functional notes
// - mode field picks off, PRBS7/9/15/31
// - user mode compares lane data to word
// - update bit rising copies all counters, unless the clear bit rises in the same write
// - clear bit rising clears all counters
// - status bit 7: counter is non-zero
// - status bit 6: lane data all zero
// - status bit 5: sequence valid but inverted
// - lane registers at group base plus lane
// - loopback bit routes tx fifo to rx
// - everything off and zero after reset
`timescale 1ns/1ps
`include "lrpc_consts.svh"

module lrpc_checker
  import lrpc_pkg::*;
#(
  parameter int LANES = 8,
  parameter int W = 32
)
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [15:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  // lane words from the receive link
  input wire logic [LANES*W-1:0] i_lane_data,
  input wire logic [LANES-1:0] i_lane_valid,
  // transmit link fifo tap for loopback
  input wire logic [LANES*W-1:0] i_tx_fifo_data,
  input wire logic [LANES-1:0] i_tx_fifo_valid,
  // receive link fifo feed
  output logic [LANES*W-1:0] o_rx_fifo_data,
  output logic [LANES-1:0] o_rx_fifo_valid,
  // interrupt
  output logic o_irq
);

  localparam int LW = (LANES > 1) ? $clog2(LANES) : 1;
  localparam int ERR_W = $clog2(W + 1);
  localparam int SUM_W = `LRPC_CNT_W + 1;

  // whole module state
  typedef struct packed {
    lrpc_shreg_t [LANES-1:0] shreg;
    lrpc_cnt_t [LANES-1:0] cnt;
    lrpc_cnt_t [LANES-1:0] shown;
    logic [LANES-1:0] invalid;
    logic [LANES-1:0] inverted;
    logic loop_en;
    logic [1:0] ctrl;
    lrpc_byte_t mode;
    logic [31:0] user;
    logic [LANES-1:0] irq_stat;
    logic [LANES-1:0] irq_mask;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    logic [LANES*W-1:0] rx_data;
    logic [LANES-1:0] rx_valid;
  } lrpc_state_s;

  lrpc_state_s st_r;
  lrpc_state_s st_nxt;

  // checks one word, msb first in time; returns {errors, shift state}
  function automatic logic [ERR_W+30:0] prbs_check(
    input lrpc_shreg_t s,
    input logic [W-1:0] d,
    input lrpc_mode_t m,
    input logic [31:0] u
  );
    lrpc_shreg_t sr;
    logic [ERR_W-1:0] e;
    logic p;
    sr = s;
    e = '0;
    p = 1'b0;
    for (int i = W - 1; i >= 0; i--)
    begin
      case (m)
        `LRPC_MODE_P7: p = sr[`LRPC_P7_TA] ^ sr[`LRPC_P7_TB];
        `LRPC_MODE_P9: p = sr[`LRPC_P9_TA] ^ sr[`LRPC_P9_TB];
        `LRPC_MODE_P15: p = sr[`LRPC_P15_TA] ^ sr[`LRPC_P15_TB];
        `LRPC_MODE_P31: p = sr[`LRPC_P31_TA] ^ sr[`LRPC_P31_TB];
        default: p = u[i]; // user word, bit for bit
      endcase
      if (p != d[i])
      begin
        e = e + ERR_W'(1);
      end
      // self-synchronising: received bit seeds the predictor
      sr = {sr[29:0], d[i]};
    end
    return {e, sr};
  endfunction

  // lane group hit: {hit, lane}
  function automatic logic [LW:0] grp(
    input lrpc_idx_t idx,
    input lrpc_idx_t base
  );
    lrpc_idx_t off;
    off = idx - base;
    return {(off < LANES), off[LW-1:0]};
  endfunction

  // one byte of a shown count, 0 is the lowest
  function automatic lrpc_byte_t cnt_byte(
    input lrpc_cnt_t c,
    input logic [1:0] b
  );
    return c[8*b +: 8];
  endfunction

  // combinational helpers
  lrpc_idx_t idx;
  logic acc;
  logic first_acc;
  logic last_acc;
  logic hit;
  lrpc_byte_t rbyte;
  lrpc_byte_t wbyte;
  logic wr_go;
  logic upd_go;
  logic clr_go;
  logic [LANES-1:0] w1c;
  logic [LANES-1:0] ev;
  logic [LW:0] g_st;
  logic [LW:0] g_lo;
  logic [LW:0] g_mid;
  logic [LW:0] g_hi;
  logic [LANES*W-1:0] chk_data;
  logic [LANES-1:0] chk_valid;
  logic mode_ok;
  logic [W-1:0] d;
  logic [ERR_W+30:0] res;
  logic [ERR_W-1:0] errs;
  logic [SUM_W-1:0] sum;

  // next state
  always_comb
  begin
    st_nxt = st_r;
    idx = i_paddr[`LRPC_IDX_MSB:`LRPC_IDX_LSB];
    acc = i_psel & i_penable;
    // first access cycle answers, second completes
    first_acc = acc & ~st_r.pready;
    last_acc = acc & st_r.pready;
    hit = 1'b1;
    rbyte = `LRPC_RESET_BYTE;
    wbyte = i_pwdata[7:0];
    upd_go = 1'b0;
    clr_go = 1'b0;
    w1c = '0;
    ev = '0;
    d = '0;
    res = '0;
    errs = '0;
    sum = '0;
    // per-lane groups sit at base plus lane
    g_st = grp(idx, `LRPC_IDX_STATUS);
    g_lo = grp(idx, `LRPC_IDX_CNT_LO);
    g_mid = grp(idx, `LRPC_IDX_CNT_MID);
    g_hi = grp(idx, `LRPC_IDX_CNT_HI);

    // read decode
    case (idx)
      `LRPC_IDX_LOOPBACK:
      begin
        rbyte = {7'h00, st_r.loop_en};
      end
      `LRPC_IDX_CTRL:
      begin
        rbyte = {6'h00, st_r.ctrl};
      end
      `LRPC_IDX_MODE:
      begin
        rbyte = st_r.mode;
      end
      `LRPC_IDX_USER0:
      begin
        rbyte = st_r.user[7:0];
      end
      `LRPC_IDX_USER1:
      begin
        rbyte = st_r.user[15:8];
      end
      `LRPC_IDX_USER2:
      begin
        rbyte = st_r.user[23:16];
      end
      `LRPC_IDX_USER3:
      begin
        rbyte = st_r.user[31:24];
      end
      `LRPC_IDX_IRQ_STAT:
      begin
        rbyte = 8'(st_r.irq_stat);
      end
      `LRPC_IDX_IRQ_MASK:
      begin
        rbyte = 8'(st_r.irq_mask);
      end
      default:
      begin
        if (g_st[LW])
        begin
          // error seen, invalid, inverted
          rbyte = {(st_r.cnt[g_st[LW-1:0]] != '0),
                   st_r.invalid[g_st[LW-1:0]],
                   st_r.inverted[g_st[LW-1:0]], 5'h00};
        end
        else if (g_lo[LW])
        begin
          rbyte = cnt_byte(st_r.shown[g_lo[LW-1:0]], 2'd0);
        end
        else if (g_mid[LW])
        begin
          rbyte = cnt_byte(st_r.shown[g_mid[LW-1:0]], 2'd1);
        end
        else if (g_hi[LW])
        begin
          rbyte = cnt_byte(st_r.shown[g_hi[LW-1:0]], 2'd2);
        end
        else
        begin
          hit = 1'b0;
        end
      end
    endcase

    // apb: answer one cycle into the access phase
    st_nxt.pready = first_acc;
    st_nxt.pslverr = first_acc & ~hit;
    if (first_acc)
    begin
      st_nxt.prdata = i_pwrite ? 32'h0 : {24'h000000, rbyte};
    end
    // write lands on the completing edge
    wr_go = last_acc & i_pwrite & hit & i_pstrb[0];

    // register writes
    if (wr_go)
    begin
      case (idx)
        `LRPC_IDX_LOOPBACK:
        begin
          st_nxt.loop_en = wbyte[`LRPC_BIT_LOOPBACK];
        end
        `LRPC_IDX_CTRL:
        begin
          // act on a 0 to 1 change only
          upd_go = wbyte[`LRPC_BIT_UPDATE] &
                   ~st_r.ctrl[`LRPC_BIT_UPDATE];
          clr_go = wbyte[`LRPC_BIT_CLEAR] &
                   ~st_r.ctrl[`LRPC_BIT_CLEAR];
          st_nxt.ctrl = wbyte[1:0];
        end
        `LRPC_IDX_MODE:
        begin
          st_nxt.mode = wbyte;
        end
        `LRPC_IDX_USER0:
        begin
          st_nxt.user[7:0] = wbyte;
        end
        `LRPC_IDX_USER1:
        begin
          st_nxt.user[15:8] = wbyte;
        end
        `LRPC_IDX_USER2:
        begin
          st_nxt.user[23:16] = wbyte;
        end
        `LRPC_IDX_USER3:
        begin
          st_nxt.user[31:24] = wbyte;
        end
        `LRPC_IDX_IRQ_STAT:
        begin
          w1c = wbyte[LANES-1:0];
        end
        `LRPC_IDX_IRQ_MASK:
        begin
          st_nxt.irq_mask = wbyte[LANES-1:0];
        end
        default:
        begin
        end
      endcase
    end

    // loopback source select
    chk_data = st_r.loop_en ? i_tx_fifo_data : i_lane_data;
    chk_valid = st_r.loop_en ? i_tx_fifo_valid : i_lane_valid;
    st_nxt.rx_data = chk_data;
    st_nxt.rx_valid = chk_valid;

    // only listed codes run the checker
    mode_ok = (st_r.mode[2:0] != `LRPC_MODE_OFF) &&
              (st_r.mode[2:0] <= `LRPC_MODE_USER);

    // per-lane checking and counting
    for (int l = 0; l < LANES; l++)
    begin
      d = chk_data[l*W +: W];
      if (chk_valid[l] && mode_ok)
      begin
        res = prbs_check(st_r.shreg[l], d, st_r.mode[2:0],
                         st_r.user);
        errs = res[ERR_W+30:31];
        st_nxt.shreg[l] = res[30:0];
        st_nxt.invalid[l] = (d == '0);
        // every bit wrong on live data means inverted
        st_nxt.inverted[l] = (d != '0) && (errs == ERR_W'(W));
        // hidden count, stops at full scale
        sum = {1'b0, st_r.cnt[l]} + SUM_W'(errs);
        st_nxt.cnt[l] = sum[`LRPC_CNT_W] ? `LRPC_CNT_MAX
                        : sum[`LRPC_CNT_W-1:0];
        ev[l] = (errs != '0);
      end
      if (clr_go)
      begin
        st_nxt.cnt[l] = '0;
        st_nxt.shown[l] = '0;
      end
      else if (upd_go)
      begin
        st_nxt.shown[l] = st_r.cnt[l];
      end
    end

    // sticky error events, set wins over clear
    st_nxt.irq_stat = (st_r.irq_stat & ~w1c) | ev;
    st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
  end

  // state register, all zero at reset
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_resetn)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from state
  assign o_pready = st_r.pready;
  assign o_prdata = st_r.prdata;
  assign o_pslverr = st_r.pslverr;
  assign o_irq = st_r.irq;

  // rx fifo feed, one lane per slice
  for (genvar gl = 0; gl < LANES; gl++)
  begin : g_rx_out
    assign o_rx_fifo_data[gl*W +: W] = st_r.rx_data[gl*W +: W];
    assign o_rx_fifo_valid[gl] = st_r.rx_valid[gl];
  end

endmodule // lrpc_checker

// ===== sim/lrpc_lane_source.sv
// link transmitter model: one test word on all eight lanes
// assumes the bench steps it on the system clock
`timescale 1ns/1ps
module lrpc_lane_source (
  // control from the bench
  input wire logic i_clk,
  input wire logic i_run,
  input wire logic [1:0] i_kind,
  input wire logic [31:0] i_word,
  input wire logic [31:0] i_flip,
  // lane words
  output logic [255:0] o_data = '0,
  output logic [7:0] o_valid = '0
);
  logic [6:0] s = 7'h7f;
  logic [31:0] w;
  // prbs7, bit 31 first in time; idle lines toggle
  always @(posedge i_clk)
  begin
    for (int k = 31; k >= 0; k--)
    begin
      w[k] = s[6] ^ s[5];
      if (i_run)
        s = {s[5:0], w[k]};
    end
    case (i_kind)
      2'd0: w = i_word;
      2'd2: w = ~w;
      2'd3: w = '0;
      default: ;
    endcase
    o_valid <= {8{i_run}};
    o_data <= i_run ? {8{w ^ i_flip}} : ~o_data;
  end
endmodule // lrpc_lane_source

// ===== sim/lrpc_checker_assertions.sv
// port assertions of the lane checker
// assumes bind onto lrpc_checker, one clock
`timescale 1ns/1ps
`include "lrpc_consts.svh"
module lrpc_checker_assertions #(
  parameter int LANES = 8,
  parameter int W = 32
)
(
  // clock, reset, apb
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [15:0] i_paddr,
  input wire logic o_pready,
  input wire logic [31:0] o_prdata,
  input wire logic o_pslverr,
  // lane paths
  input wire logic [LANES*W-1:0] i_lane_data,
  input wire logic [LANES-1:0] i_lane_valid,
  input wire logic [LANES*W-1:0] i_tx_fifo_data,
  input wire logic [LANES-1:0] i_tx_fifo_valid,
  input wire logic [LANES*W-1:0] o_rx_fifo_data,
  input wire logic [LANES-1:0] o_rx_fifo_valid
);
  logic [11:0] ix;
  logic mapped;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  // register map decode
  assign ix = i_paddr[13:2];
  assign mapped = ix == `LRPC_IDX_LOOPBACK || ix == `LRPC_IDX_CTRL
    || (ix >= `LRPC_IDX_MODE && ix <= `LRPC_IDX_USER3)
    || ix == `LRPC_IDX_IRQ_STAT || ix == `LRPC_IDX_IRQ_MASK;
  sequence setup_sq;
    i_psel && !i_penable;
  endsequence
  sequence access_sq;
    i_psel && i_penable && !o_pready;
  endsequence
  AST_ONE_WAIT: assert property (setup_sq ##1 access_sq |=> o_pready)
    else $error("apb answer late");
  AST_PULSE: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  AST_UNMAPPED: assert property (access_sq ##0 !mapped |=> o_pslverr)
    else $error("unmapped access without error");
  AST_MAPPED: assert property (access_sq ##0 mapped |=> !o_pslverr)
    else $error("mapped access flagged");
  AST_BYTE: assert property (o_pready |-> o_prdata[31:8] == 24'h0)
    else $error("read data above byte");
  AST_RX_SRC: assert property (|o_rx_fifo_valid |->
    (o_rx_fifo_data == $past(i_lane_data)
    && o_rx_fifo_valid == $past(i_lane_valid))
    || (o_rx_fifo_data == $past(i_tx_fifo_data)
    && o_rx_fifo_valid == $past(i_tx_fifo_valid)))
    else $error("rx fifo from no source");
  AST_RX_QUIET: assert property (!(|i_lane_valid) && !(|i_tx_fifo_valid)
    |=> o_rx_fifo_valid == '0) else $error("rx valid with no input");
  AST_RST: assert property (disable iff (1'b0) !i_resetn
    |=> !o_pready && o_rx_fifo_valid == '0) else $error("busy after reset");
endmodule // lrpc_checker_assertions

// ===== sim/test_lrpc_checker.sv
// self-checking bench of the lane checker
// assumes lrpc_consts.svh on the include path
`timescale 1ns/1ps
`include "lrpc_consts.svh"
module test_lrpc_checker;
  logic i_sys_clk = 0, i_resetn = 0, i_psel = 0, i_penable = 0;
  logic i_pwrite = 0, run = 0, err;
  logic [1:0] kind = 0;
  logic [3:0] i_pstrb = 4'h1;
  logic [15:0] i_paddr = '0;
  logic [23:0] e;
  logic [31:0] i_pwdata = '0, uword = '0, flip = '0, q, o_prdata;
  logic [31:0] seed = 32'h46e935e4;
  logic [255:0] i_lane_data, i_tx_fifo_data = '0, o_rx_fifo_data;
  logic [7:0] i_lane_valid, i_tx_fifo_valid = '0, o_rx_fifo_valid;
  logic o_pready, o_pslverr, o_irq;
  logic [11:0] ri [9] = '{`LRPC_IDX_LOOPBACK, `LRPC_IDX_CTRL,
    `LRPC_IDX_MODE, `LRPC_IDX_STATUS + 12'd7, `LRPC_IDX_CNT_LO,
    `LRPC_IDX_CNT_HI + 12'd7, `LRPC_IDX_USER0, `LRPC_IDX_USER3,
    `LRPC_IDX_IRQ_STAT};
  int bad_count = 0, samples_checked = 0;
  lrpc_checker uut (.*);
  lrpc_lane_source src (.i_clk(i_sys_clk), .i_run(run), .i_kind(kind),
    .i_word(uword), .i_flip(flip), .o_data(i_lane_data),
    .o_valid(i_lane_valid));
  initial forever #10 i_sys_clk = ~i_sys_clk;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic [23:0] cnt_exp(input int n, logic [31:0] f);
    return 24'(n * $countones(f));
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer; q and err hold the answer
  task automatic apb(input logic wr, input logic [11:0] a, logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    i_psel <= 1;
    i_pwrite <= wr;
    i_paddr <= {2'b00, a, 2'b00};
    i_pwdata <= {24'h0, d};
    @(posedge i_sys_clk);
    i_penable <= 1;
    @(posedge i_sys_clk);
    while (o_pready !== 1'b1 && n < 50)
    begin
      @(posedge i_sys_clk);
      n++;
    end
    if (n == 50)
    begin
      bad_count++;
      give_verdict();
    end
    q = o_prdata;
    err = o_pslverr;
    i_psel <= 0;
    i_penable <= 0;
  endtask
  task automatic rdc(input logic [11:0] a, logic [7:0] x);
    apb(0, a, 8'h00);
    chk($sformatf("reg %h", a), q, {24'h0, x});
  endtask
  task automatic send(input int n);
    run <= 1;
    repeat (n) @(posedge i_sys_clk);
    run <= 0;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog
  initial
  begin
    repeat (20000) @(posedge i_sys_clk);
    bad_count++;
    give_verdict();
  end
  initial
  begin
    repeat (8) @(posedge i_sys_clk);
    i_resetn <= 1;
    foreach (ri[k]) rdc(ri[k], 8'h00);
    apb(0, 12'h951, 8'h00);
    chk("unmapped", err, 1);
    $display("reset map done");
    seed = xs(seed);
    uword <= seed;
    for (int i = 0; i < 4; i++)
      apb(1, `LRPC_IDX_USER0 + 12'(i), seed[8*i +: 8]);
    apb(1, `LRPC_IDX_MODE, `LRPC_MODE_USER);
    apb(1, `LRPC_IDX_CTRL, 8'h01);
    send(4);
    flip <= xs(seed);
    send(10);
    flip <= '0;
    rdc(`LRPC_IDX_CNT_LO, 8'h00);
    rdc(`LRPC_IDX_STATUS, 8'h80);
    apb(1, `LRPC_IDX_CTRL, 8'h02);
    e = cnt_exp(10, xs(seed));
    rdc(`LRPC_IDX_CNT_LO + 12'd7, e[7:0]);
    rdc(`LRPC_IDX_CNT_MID + 12'd7, e[15:8]);
    rdc(`LRPC_IDX_CNT_HI + 12'd7, e[23:16]);
    rdc(`LRPC_IDX_IRQ_STAT, 8'hff);
    apb(1, `LRPC_IDX_IRQ_MASK, 8'h80);
    @(negedge i_sys_clk);
    chk("irq", o_irq, 1);
    apb(1, `LRPC_IDX_IRQ_STAT, 8'h80);
    @(negedge i_sys_clk);
    chk("irq", o_irq, 0);
    apb(1, `LRPC_IDX_CTRL, 8'h01);
    rdc(`LRPC_IDX_CNT_MID + 12'd7, 8'h00);
    rdc(`LRPC_IDX_STATUS + 12'd7, 8'h00);
    $display("user mode done");
    kind <= 2'd1;
    apb(1, `LRPC_IDX_MODE, `LRPC_MODE_P7);
    send(8);
    apb(1, `LRPC_IDX_CTRL, 8'h00);
    apb(1, `LRPC_IDX_CTRL, 8'h01);
    send(20);
    apb(1, `LRPC_IDX_CTRL, 8'h02);
    rdc(`LRPC_IDX_CNT_LO + 12'd3, 8'h00);
    kind <= 2'd2;
    send(4);
    rdc(`LRPC_IDX_STATUS + 12'd3, 8'ha0);
    kind <= 2'd3;
    for (int m = 1; m < 6; m++)
    begin
      apb(1, `LRPC_IDX_MODE, 8'(m));
      send(2);
      rdc(`LRPC_IDX_STATUS + 12'(m), 8'hc0);
    end
    $display("prbs modes done");
    apb(1, `LRPC_IDX_LOOPBACK, 8'h01);
    seed = xs(seed);
    i_tx_fifo_data <= {8{seed}};
    i_tx_fifo_valid <= seed[7:0];
    @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    chk("loop data", o_rx_fifo_data[255:224], seed);
    chk("loop valid", o_rx_fifo_valid, seed[7:0]);
    apb(1, `LRPC_IDX_LOOPBACK, 8'h00);
    @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    chk("normal valid", o_rx_fifo_valid, 8'h00);
    @(posedge i_sys_clk);
    i_tx_fifo_valid <= '0;
    i_resetn <= 0;
    repeat (2) @(posedge i_sys_clk);
    i_resetn <= 1;
    rdc(`LRPC_IDX_MODE, 8'h00);
    rdc(`LRPC_IDX_STATUS + 12'd3, 8'h00);
    rdc(`LRPC_IDX_IRQ_STAT, 8'h00);
    $display("loopback and reset done");
    give_verdict();
  end
endmodule // test_lrpc_checker
bind lrpc_checker lrpc_checker_assertions #(.LANES(LANES), .W(W)) u_ast (.*);
